// ---- rtl/stp_pkg.sv ----
// Function
// - Three control bits, the boost bit and the two step-select bits, pick one of five modes.
// - Both step-select bits low and boost low gives two-phase full stepping at the normal vector.
// - Full stepping with boost high drives both phases together for the raised 141% vector.
// - The half-step flag is low only where the low three position bits equal 4, the full-step burst positions, and high elsewhere.
// - The motor advances one full step per eight input clocks in every mode.
// - One serial burst per eight input clocks in full-step modes, one per four in half-step mode.
// - One burst per two input clocks in quarter-step mode and one per input clock in eighth-step.
// - A burst is bit clocks, phase A and B serial data and a latch strobe on the link clock.
// - Eighth stepping walks a 3-bit current-ratio index, eight divisions per step.
// - Clear empties the sequence counter; otherwise it moves in the selected direction.
// - Both step-select bits high gives eighth stepping with a burst for each increment.
// - Step-select low bit low and high bit high gives quarter stepping.
package stp_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int CTRL_SEL_LO_BIT = 0;
    localparam int CTRL_SEL_HI_BIT = 1;
    localparam int CTRL_BOOST_BIT = 2;
    localparam int CTRL_DIR_BIT = 3;
    localparam int CTRL_CLEAR_BIT = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h10;
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_FLAG_BIT = 5;
    localparam int STAT_BUSY_BIT = 6;
    localparam int STAT_OVR_BIT = 7;
    localparam int POS_W = 5;
    localparam int IDX_W = 3;
    localparam int WORD_W = 4;
    localparam logic [2:0] HALF_POS = 3'h4;
    localparam logic [2:0] IDX_71 = 3'h4;
    localparam logic [2:0] IDX_100 = 3'h7;

    typedef enum logic [2:0] {
        MODE_FULL, MODE_BOOST, MODE_HALF, MODE_QUARTER, MODE_EIGHTH
    } stp_mode_type;

    function automatic stp_mode_type mode_of(input logic lo, input logic hi, input logic boost);
        if (lo && hi) begin
            return MODE_EIGHTH;
        end else if (hi) begin
            return MODE_QUARTER;
        end else if (lo) begin
            return MODE_HALF;
        end
        return boost ? MODE_BOOST : MODE_FULL;
    endfunction : mode_of

    // Burst positions on the 32-division electrical cycle
    function automatic logic burst_due(input stp_mode_type m, input logic [POS_W-1:0] p);
        unique case (m)
            MODE_EIGHTH: return 1'b1;
            MODE_QUARTER: return p[0] == 1'b0;
            MODE_HALF: return p[1:0] == 2'h0;
            MODE_FULL, MODE_BOOST: return p[2:0] == HALF_POS;
        endcase
    endfunction : burst_due

    // Falling phase of a quadrant, 3-bit ratio index
    function automatic logic [IDX_W-1:0] ratio_fall(input logic [2:0] k);
        logic [IDX_W-1:0] t [8];
        t = '{3'h7, 3'h6, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
        return t[k];
    endfunction : ratio_fall
endpackage : stp_pkg

// ---- rtl/stp_seq.sv ----
module stp_seq #(
    parameter int ADDR_W = 8,
    parameter int WORD_W = stp_pkg::WORD_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic step_clk,
    input wire logic link_clk,
    output logic bit_clk,
    output logic ser_a,
    output logic ser_b,
    output logic latch_strobe,
    output logic half_step_flag
);
    localparam int PW = stp_pkg::POS_W;

    // Register file and sequencer state
    logic [stp_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [31:0] prdata_q, prdata_d;
    logic [PW-1:0] pos_q, pos_d;
    logic flag_q, flag_d;
    logic ovr_q, ovr_d;
    logic req_q, req_d;
    logic [WORD_W-1:0] word_a_q, word_a_d, word_b_q, word_b_d;
    logic [2:0] stp_sync_q;
    logic ack_s1_q, ack_s2_q;
    logic ack_seen_q, ack_seen_d;

    logic step_rise, idle, due, wr_ctrl, wr_stat, hit;
    logic [PW-1:0] pos_next;
    stp_pkg::stp_mode_type mode;

    // Register bits passed as arguments so the decode follows every write
    assign mode = stp_pkg::mode_of(ctrl_q[stp_pkg::CTRL_SEL_LO_BIT],
        ctrl_q[stp_pkg::CTRL_SEL_HI_BIT], ctrl_q[stp_pkg::CTRL_BOOST_BIT]);

    // Phase word: sign then magnitude; odd quadrants swap the two ratio curves
    function automatic logic [WORD_W-1:0] phase_word(input stp_pkg::stp_mode_type m,
            input logic [PW-1:0] p, input logic is_b);
        logic [2:0] k;
        logic [stp_pkg::IDX_W-1:0] mag;
        logic sgn;
        k = p[2:0];
        mag = (p[3] ^ is_b) ? stp_pkg::ratio_fall(3'(~k + 3'h1)) : stp_pkg::ratio_fall(k);
        if ((p[3] ^ is_b) && k == 3'h0) begin
            mag = '0;
        end
        if (m == stp_pkg::MODE_BOOST) begin
            mag = stp_pkg::IDX_100;
        end else if (m == stp_pkg::MODE_FULL) begin
            mag = stp_pkg::IDX_71;
        end
        sgn = is_b ? p[4] : (p[4] ^ p[3]);
        return WORD_W'({sgn, mag});
    endfunction : phase_word

    assign step_rise = stp_sync_q[1] & ~stp_sync_q[2];
    assign idle = (req_q == ack_s2_q);
    assign hit = (paddr == ADDR_W'(stp_pkg::CTRL_OFFSET))
        || (paddr == ADDR_W'(stp_pkg::STATUS_OFFSET));
    assign wr_ctrl = psel & penable & pwrite & (paddr == ADDR_W'(stp_pkg::CTRL_OFFSET));
    assign wr_stat = psel & penable & pwrite & (paddr == ADDR_W'(stp_pkg::STATUS_OFFSET));
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_q;
    assign half_step_flag = flag_q;

    always_comb begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pos_d = pos_q;
        flag_d = flag_q;
        ovr_d = ovr_q;
        req_d = req_q;
        word_a_d = word_a_q;
        word_b_d = word_b_q;
        pos_next = ctrl_q[stp_pkg::CTRL_DIR_BIT] ? pos_q - PW'(1) : pos_q + PW'(1);
        due = 1'b0;
        if (wr_ctrl) begin
            ctrl_d = pwdata[stp_pkg::CTRL_W-1:0];
        end
        if (wr_stat && pwdata[stp_pkg::STAT_OVR_BIT]) begin
            ovr_d = 1'b0;
        end
        // Read data captured in the setup cycle so it stands through the access
        if (psel && !penable) begin
            prdata_d = '0;
            if (paddr == ADDR_W'(stp_pkg::CTRL_OFFSET)) begin
                prdata_d[stp_pkg::CTRL_W-1:0] = ctrl_q;
            end else if (paddr == ADDR_W'(stp_pkg::STATUS_OFFSET)) begin
                prdata_d[stp_pkg::STAT_POS_LSB +: PW] = pos_q;
                prdata_d[stp_pkg::STAT_FLAG_BIT] = flag_q;
                prdata_d[stp_pkg::STAT_BUSY_BIT] = ~idle;
                prdata_d[stp_pkg::STAT_OVR_BIT] = ovr_q;
            end
        end
        if (ctrl_q[stp_pkg::CTRL_CLEAR_BIT]) begin
            pos_d = '0;
        end else if (step_rise) begin
            pos_d = pos_next;
            due = stp_pkg::burst_due(mode, pos_next);
        end
        flag_d = (pos_d[2:0] != stp_pkg::HALF_POS);
        // A burst still on the link cannot be cut short; the step is flagged as lost
        if (due && idle) begin
            req_d = ~req_q;
            word_a_d = phase_word(mode, pos_d, 1'b0);
            word_b_d = phase_word(mode, pos_d, 1'b1);
        end else if (due) begin
            ovr_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= stp_pkg::CTRL_RESET;
            prdata_q <= '0;
            pos_q <= '0;
            flag_q <= 1'b1;
            ovr_q <= 1'b0;
            req_q <= 1'b0;
            word_a_q <= '0;
            word_b_q <= '0;
            stp_sync_q <= '0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pos_q <= pos_d;
            flag_q <= flag_d;
            ovr_q <= ovr_d;
            req_q <= req_d;
            word_a_q <= word_a_d;
            word_b_q <= word_b_d;
            stp_sync_q <= {stp_sync_q[1:0], step_clk};
            ack_s1_q <= ack_seen_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // Link side: shifts one burst per toggle of the request
    typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH, L_STROBE} stp_link_type;
    stp_link_type lst_q, lst_d;
    logic req_l1_q, req_l2_q;
    logic [WORD_W-1:0] sh_a_q, sh_a_d, sh_b_q, sh_b_d;
    logic [$clog2(WORD_W+1)-1:0] bcnt_q, bcnt_d;
    logic bclk_q, bclk_d, sa_q, sa_d, sb_q, sb_d, stb_q, stb_d;

    always_comb begin
        lst_d = lst_q;
        ack_seen_d = ack_seen_q;
        sh_a_d = sh_a_q;
        sh_b_d = sh_b_q;
        bcnt_d = bcnt_q;
        bclk_d = 1'b0;
        sa_d = sa_q;
        sb_d = sb_q;
        stb_d = 1'b0;
        unique case (lst_q)
            L_IDLE: begin
                if (req_l2_q != ack_seen_q) begin
                    sh_a_d = word_a_q;
                    sh_b_d = word_b_q;
                    bcnt_d = ($bits(bcnt_q))'(WORD_W);
                    lst_d = L_LOW;
                end
            end
            L_LOW: begin
                sa_d = sh_a_q[WORD_W-1];
                sb_d = sh_b_q[WORD_W-1];
                lst_d = L_HIGH;
            end
            L_HIGH: begin
                bclk_d = 1'b1;
                sh_a_d = sh_a_q << 1;
                sh_b_d = sh_b_q << 1;
                bcnt_d = bcnt_q - 1'b1;
                lst_d = (bcnt_q == 1) ? L_STROBE : L_LOW;
            end
            L_STROBE: begin
                stb_d = 1'b1;
                ack_seen_d = req_l2_q;
                lst_d = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lst_q <= L_IDLE;
            req_l1_q <= 1'b0;
            req_l2_q <= 1'b0;
            ack_seen_q <= 1'b0;
            sh_a_q <= '0;
            sh_b_q <= '0;
            bcnt_q <= '0;
            bclk_q <= 1'b0;
            sa_q <= 1'b0;
            sb_q <= 1'b0;
            stb_q <= 1'b0;
        end else begin
            lst_q <= lst_d;
            req_l1_q <= req_q;
            req_l2_q <= req_l1_q;
            ack_seen_q <= ack_seen_d;
            sh_a_q <= sh_a_d;
            sh_b_q <= sh_b_d;
            bcnt_q <= bcnt_d;
            bclk_q <= bclk_d;
            sa_q <= sa_d;
            sb_q <= sb_d;
            stb_q <= stb_d;
        end
    end

    assign bit_clk = bclk_q;
    assign ser_a = sa_q;
    assign ser_b = sb_q;
    assign latch_strobe = stb_q;

    logic clr, dir;
    assign clr = ctrl_q[stp_pkg::CTRL_CLEAR_BIT];
    assign dir = ctrl_q[stp_pkg::CTRL_DIR_BIT];

    a_pos_forward: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_rise && !clr && !dir |=> pos_q == PW'($past(pos_q) + 1))
        else $error("position did not advance by one");
    a_pos_reverse: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_rise && !clr && dir |=> pos_q == PW'($past(pos_q) - 1))
        else $error("position did not move back by one");
    a_pos_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr |=> pos_q == '0)
        else $error("clear did not empty the counter");
    a_half_flag: assert property (@(posedge pclk) disable iff (!presetn)
        half_step_flag == (pos_q[2:0] != stp_pkg::HALF_POS))
        else $error("half-step flag disagrees with position");
    a_eighth_burst: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_rise && !clr && idle && mode == stp_pkg::MODE_EIGHTH |=> req_q != $past(req_q))
        else $error("eighth step missed a burst");
    a_quarter_skip: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_rise && !clr && mode == stp_pkg::MODE_QUARTER && pos_next[0]
        |=> $stable(req_q))
        else $error("quarter step burst on odd position");
    a_full_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_rise && !clr && mode == stp_pkg::MODE_FULL && pos_next[2:0] != 3'h4
        |=> $stable(req_q))
        else $error("full step burst off a half-step position");
    a_boost_word: assert property (@(posedge pclk) disable iff (!presetn)
        ce && due && idle && mode == stp_pkg::MODE_BOOST
        |=> word_a_q[2:0] == 3'h7 && word_b_q[2:0] == 3'h7)
        else $error("boost did not drive both phases fully");
    a_strobe_once: assert property (@(posedge link_clk) disable iff (!presetn)
        latch_strobe |=> !latch_strobe && !bit_clk)
        else $error("strobe longer than one link cycle");
    a_clock_pair: assert property (@(posedge link_clk) disable iff (!presetn)
        bit_clk |-> $past(!bit_clk) && $stable(ser_a))
        else $error("bit clock high without a low half");
    a_strobe_last: assert property (@(posedge link_clk) disable iff (!presetn)
        latch_strobe |-> $past(bit_clk))
        else $error("strobe not right after the last bit");
    a_link_rest: assert property (@(posedge link_clk) disable iff (!presetn)
        lst_q == L_IDLE |-> !bit_clk)
        else $error("bit clock moved outside a burst");
    // A dropped burst must leave a trace that software can read
    a_ovr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ce && due && !idle |=> ovr_q)
        else $error("lost burst not flagged");
    a_clear_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        ce && clr |=> $stable(req_q))
        else $error("burst requested while cleared");
    a_half_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_rise && !clr && mode == stp_pkg::MODE_HALF && pos_next[1:0] != 2'h0
        |=> $stable(req_q))
        else $error("half step burst off a half position");
    a_full_word: assert property (@(posedge pclk) disable iff (!presetn)
        ce && due && idle && mode == stp_pkg::MODE_FULL
        |=> word_a_q[2:0] == 3'h4 && word_b_q[2:0] == 3'h4)
        else $error("normal full step ratio wrong");
    a_whole_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && due && idle && mode == stp_pkg::MODE_EIGHTH && pos_d[2:0] == 3'h0
        |=> {word_a_q[2:0], word_b_q[2:0]} inside {6'h38, 6'h07})
        else $error("whole step did not carry one phase alone");
    a_mode_eighth: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[stp_pkg::CTRL_SEL_LO_BIT] && ctrl_q[stp_pkg::CTRL_SEL_HI_BIT]
        |-> mode == stp_pkg::MODE_EIGHTH)
        else $error("eighth step not decoded");
    a_mode_quarter: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[stp_pkg::CTRL_SEL_LO_BIT] && ctrl_q[stp_pkg::CTRL_SEL_HI_BIT]
        |-> mode == stp_pkg::MODE_QUARTER)
        else $error("quarter step not decoded");
    a_mode_half: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[stp_pkg::CTRL_SEL_LO_BIT] && !ctrl_q[stp_pkg::CTRL_SEL_HI_BIT]
        |-> mode == stp_pkg::MODE_HALF)
        else $error("half step not decoded");
endmodule : stp_seq

// ---- verification/stepper_parallel_to_serial_sequencer_tb.sv ----
module stepper_parallel_to_serial_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic step_clk = 0, link_clk = 0, sb_off = 0, dir = 0, clr = 1, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, bit_clk, ser_a, ser_b, latch_strobe, half_step_flag;
    logic [3:0] word_a, word_b, n_bits;
    logic [7:0] n_words;
    logic [4:0] pos = 5'h00;
    logic [7:0] exp_q [$];
    logic [4:0] ctrl_tab [6] = '{5'h01, 5'h02, 5'h03, 5'h00, 5'h04, 5'h07};
    int mismatches = 0, n_checks = 0, cyc = 0, mode = 0, n;
    always #20 pclk = ~pclk;
    // Link clock offset so its edges never line up with pclk
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    stp_seq i_stp_seq (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .step_clk(step_clk), .link_clk(link_clk), .bit_clk(bit_clk),
        .ser_a(ser_a), .ser_b(ser_b), .latch_strobe(latch_strobe),
        .half_step_flag(half_step_flag));
    stp_drv_model i_stp_drv_model (.bit_clk(bit_clk), .ser_a(ser_a), .ser_b(ser_b),
        .latch_strobe(latch_strobe), .word_a(word_a), .word_b(word_b), .n_bits(n_bits),
        .n_words(n_words));
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    function automatic logic [3:0] ratio(input int k);
        logic [3:0] t [8];
        t = '{4'h7, 4'h6, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
        return (k > 7) ? 4'h0 : t[k];
    endfunction : ratio
    // Words {sign, index} for A then B at one position
    function automatic logic [7:0] exp_word(input logic [4:0] p, input int m);
        logic [3:0] a, b;
        a = p[3] ? ratio(8 - p[2:0]) : ratio(p[2:0]);
        b = p[3] ? ratio(p[2:0]) : ratio(8 - p[2:0]);
        if (m < 2) a = (m == 0) ? 4'h4 : 4'h7;
        if (m < 2) b = a;
        a[3] = p[4] ^ p[3];
        b[3] = p[4];
        return {a, b};
    endfunction : exp_word
    function automatic logic due(input logic [4:0] p, input int m);
        if (m == 4) return 1'b1;
        if (m == 3) return ~p[0];
        if (m == 2) return p[1:0] == 2'h0;
        return p[2:0] == 3'h4;
    endfunction : due
    task set_ctrl(input logic [4:0] c);
        apb(1, stp_pkg::CTRL_OFFSET, {27'h0, c});
        chk("ctrl write err", err, 0);
        mode = (c[0] & c[1]) ? 4 : c[1] ? 3 : c[0] ? 2 : c[2] ? 1 : 0;
        dir = c[3];
        clr = c[4];
        if (clr) pos = 5'h00;
    endtask : set_ctrl
    task step(input int hi, input int lo);
        @(posedge pclk);
        step_clk <= 1;
        if (!clr) pos = dir ? pos - 5'h01 : pos + 5'h01;
        if (!clr && !sb_off && due(pos, mode)) exp_q.push_back(exp_word(pos, mode));
        repeat (hi) @(posedge pclk);
        step_clk <= 0;
        repeat (lo) @(posedge pclk);
    endtask : step
    task step_chk;
        step(6, 6);
        apb(0, stp_pkg::STATUS_OFFSET, 32'h0);
        chk("status pos", rd[5:0], {pos[2:0] != 3'h4, pos});
        chk("flag pin", half_step_flag, pos[2:0] != 3'h4);
    endtask : step_chk
    // Scoreboard: each latched burst is matched against the oldest note
    always @(n_words) begin : mon_blk
        logic [7:0] e, m;
        if (n_words !== 8'h00 && !sb_off) begin
            if (exp_q.size() == 0) begin
                chk("unexpected burst", 1, 0);
            end else begin
                e = exp_q.pop_front();
                m = {(e[6:4] == 3'h0) ? 4'h7 : 4'hf, (e[2:0] == 3'h0) ? 4'h7 : 4'hf};
                chk("burst words", {word_a, word_b} & m, e & m);
                chk("bit count", n_bits, stp_pkg::WORD_W);
            end
        end
    end
    initial begin
        void'($urandom(32'h0473));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, stp_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl reset", rd, 32'h10);
        apb(0, stp_pkg::STATUS_OFFSET, 32'h0);
        chk("status reset", rd, 32'h20);
        apb(0, 8'h08, 32'h0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        step_chk();
        ce <= 0;
        apb(1, stp_pkg::CTRL_OFFSET, 32'h0);
        ce <= 1;
        apb(0, stp_pkg::CTRL_OFFSET, 32'h0);
        chk("ce write lost", rd, 32'h10);
        $display("test reset done");
        set_ctrl(5'h08);
        repeat (4) step_chk();
        // Host changes mode only with the flag low; boost moves only in full step
        for (int i = 0; i < 6; i++) begin
            set_ctrl(ctrl_tab[i] | {1'b0, 1'($urandom % 2), 3'h0});
            n = 8 * (1 + $urandom % 2);
            repeat (n) step_chk();
            $display("test mode %0d done", i);
        end
        repeat (40) @(posedge pclk);
        chk("bursts missing", exp_q.size(), 0);
        sb_off = 1;
        repeat (8) step(3, 3);
        repeat (60) @(posedge pclk);
        exp_q.delete();
        sb_off = 0;
        apb(0, stp_pkg::STATUS_OFFSET, 32'h0);
        chk("overrun set", rd[7:0], {2'b10, pos[2:0] != 3'h4, pos});
        apb(1, stp_pkg::STATUS_OFFSET, 32'h80);
        apb(0, stp_pkg::STATUS_OFFSET, 32'h0);
        chk("overrun cleared", rd[7], 0);
        $display("test overrun done");
        set_ctrl(5'h17);
        step_chk();
        $display("test clear done");
        give_verdict();
    end
endmodule : stepper_parallel_to_serial_sequencer_tb

// ---- verification/stp_drv_model.sv ----
module stp_drv_model (
    input wire logic bit_clk,
    input wire logic ser_a,
    input wire logic ser_b,
    input wire logic latch_strobe,
    output logic [stp_pkg::WORD_W-1:0] word_a,
    output logic [stp_pkg::WORD_W-1:0] word_b,
    output logic [3:0] n_bits,
    output logic [7:0] n_words
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [stp_pkg::WORD_W-1:0] sh_a, sh_b;
    logic [3:0] cnt;
    initial begin
        {sh_a, sh_b, cnt, word_a, word_b, n_bits, n_words} = '0;
    end
    // Shift on the bit clock rise, MSB first, both phases in parallel
    always @(posedge bit_clk or posedge latch_strobe) begin
        if (latch_strobe) begin
            word_a <= sh_a;
            word_b <= sh_b;
            n_bits <= cnt;
            cnt <= 4'h0;
            n_words <= n_words + 8'h01;
        end else begin
            sh_a <= {sh_a[stp_pkg::WORD_W-2:0], ser_a};
            sh_b <= {sh_b[stp_pkg::WORD_W-2:0], ser_b};
            cnt <= cnt + 4'h1;
        end
    end
endmodule : stp_drv_model
